// ### include/cssx_pkg.sv
// constants for the compact shift, subtract and store execute block
package cssx_pkg;
    localparam int XLEN = 32;
    localparam logic [4:0] OP_EXTEND = 5'h1E;
    localparam logic [4:0] OP_SHIFT = 5'h06;
    localparam logic [4:0] OP_TWO_REG = 5'h1D;
    localparam logic [4:0] OP_THREE_REG = 5'h1C;
    localparam logic [4:0] OP_WORD_STORE = 5'h1B;
    localparam logic [4:0] OP_STACK_STORE = 5'h1A;
    localparam logic [1:0] FN_ARITH_SHIFT = 2'h3;
    localparam logic [1:0] FN_LOGIC_SHIFT = 2'h2;
    localparam logic [1:0] FN_SUBTRACT = 2'h3;
    localparam logic [4:0] FN_ARITH_VAR = 5'h07;
    localparam logic [4:0] FN_LOGIC_VAR = 5'h06;
    localparam logic [5:0] EXT_SHIFT_ZERO = 6'h00;
    localparam logic [4:0] SHORT_ZERO_AMT = 5'h08;
    localparam logic [4:0] STACK_REG = 5'h1D;
    localparam logic [1:0] ALIGN_OK = 2'h0;
    // 3-bit register field to general register index
    localparam logic [4:0] XLAT0 = 5'h10;
    localparam logic [4:0] XLAT1 = 5'h11;
    localparam logic [1:0] UNMAPPED_SEG = 2'h2;
    localparam logic [2:0] CCA_UNCACHED = 3'h2;
    localparam logic [2:0] CCA_CACHED = 3'h3;
    localparam logic [XLEN-1:0] GPR_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        CSSX_OP_NONE = 3'b000,
        CSSX_OP_SHIFT_IMM = 3'b001,
        CSSX_OP_SHIFT_VAR = 3'b010,
        CSSX_OP_SUBTRACT = 3'b011,
        CSSX_OP_STORE = 3'b100
    } cssx_op_t;
endpackage

// ### verilog/cssx_exec.sv
// decoder and executor for compact right shifts, subtract and word stores
//
// Operation
// RQ1 - short shift field zero means eight
// RQ2 - arithmetic shift fills with source bit 31
// RQ3 - logical shift fills with zeros
// RQ4 - extended shift: prefix, 5-bit amount, zeros
// RQ5 - immediate shift opcode and function decode
// RQ6 - variable shift decode, amount from register
// RQ7 - variable shift writes back shifted register
// RQ8 - three-register subtract into third field
// RQ9 - subtract never traps on overflow
// RQ10 - short store: offset times four, zero-extended
// RQ11 - extended store: 16-bit signed unscaled offset
// RQ12 - short stack store: offset times four, r29
// RQ13 - extended stack store: signed offset plus r29
// RQ14 - misaligned store: address error, no write
// RQ15 - aligned store: translate, then write word
// RQ16 - fixed translation of 3-bit register fields
`timescale 1ns/100ps
`default_nettype none
module cssx_exec #(
    parameter int NUM_GPR = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic instr_ext,
    input wire logic [31:0] instr_word,
    input wire logic gpr_wr_en,
    input wire logic [4:0] gpr_wr_idx,
    input wire logic [31:0] gpr_wr_data,
    input wire logic [4:0] gpr_rd_idx,
    output logic [31:0] gpr_rd_data,
    output logic wb_en,
    output logic [4:0] wb_idx,
    output logic [31:0] wb_val,
    output logic st_valid,
    output logic [31:0] st_vaddr,
    output logic [31:0] st_paddr,
    output logic [2:0] st_cca,
    output logic [31:0] st_data,
    output logic addr_err,
    output logic [31:0] bad_vaddr,
    output logic illegal
);
    if (NUM_GPR != 32) begin : gpr_count_chk
        $error("cssx_exec serves exactly 32 general registers");
    end

    // fields 0 and 1 reach the high pair; the rest map to themselves
    function automatic logic [4:0] xlat(input logic [2:0] f); // RQ16
        return (f[2:1] == 2'h0) ? (f[0] ? cssx_pkg::XLAT1 : cssx_pkg::XLAT0)
                                : {2'h0, f};
    endfunction

    logic [31:0] gpr_q [NUM_GPR];
    function automatic logic [31:0] rd(input logic [4:0] i);
        return (i == 5'h00) ? 32'h0000_0000 : gpr_q[i];
    endfunction

    logic [15:0] h, ext_off;
    logic [4:0] major, shamt, dst;
    logic ext_ok, arith, bad;
    logic [31:0] off_sx, sh_src, sh_res, sub_a, sub_b;
    logic [31:0] st_base, st_off, vaddr, sdata;
    cssx_pkg::cssx_op_t op;

    assign h = instr_word[15:0];
    assign major = h[15:11];
    assign ext_ok = !instr_ext || (instr_word[31:27] == cssx_pkg::OP_EXTEND);
    assign ext_off = {instr_word[20:16], instr_word[26:21], h[4:0]};
    assign off_sx = {{16{ext_off[15]}}, ext_off};

    always_comb begin
        op = cssx_pkg::CSSX_OP_NONE;
        arith = 1'b0;
        shamt = 5'h00;
        sh_src = rd(xlat(h[7:5]));
        dst = xlat(h[10:8]);
        st_base = rd(xlat(h[10:8]));
        st_off = 32'h0000_0000;
        sdata = rd(xlat(h[7:5]));
        sub_a = rd(xlat(h[10:8]));
        sub_b = rd(xlat(h[7:5]));
        bad = !ext_ok;
        unique case (major)
            cssx_pkg::OP_SHIFT: begin
                // immediate shift; left shifts belong elsewhere
                arith = (h[1:0] == cssx_pkg::FN_ARITH_SHIFT); // RQ5
                if (h[1:0] == cssx_pkg::FN_ARITH_SHIFT ||
                    h[1:0] == cssx_pkg::FN_LOGIC_SHIFT) begin
                    op = cssx_pkg::CSSX_OP_SHIFT_IMM;
                end else begin
                    bad = 1'b1;
                end
                if (instr_ext) begin
                    shamt = instr_word[26:22]; // RQ4
                    if (instr_word[21:16] != cssx_pkg::EXT_SHIFT_ZERO ||
                        h[4:2] != 3'h0) begin
                        bad = 1'b1; // RQ4
                    end
                end else if (h[4:2] == 3'h0) begin
                    shamt = cssx_pkg::SHORT_ZERO_AMT; // RQ1
                end else begin
                    shamt = {2'h0, h[4:2]}; // RQ1
                end
            end
            cssx_pkg::OP_TWO_REG: begin
                arith = (h[4:0] == cssx_pkg::FN_ARITH_VAR); // RQ6
                if (h[4:0] == cssx_pkg::FN_ARITH_VAR ||
                    h[4:0] == cssx_pkg::FN_LOGIC_VAR) begin
                    op = cssx_pkg::CSSX_OP_SHIFT_VAR;
                end else begin
                    bad = 1'b1;
                end
                shamt = 5'(rd(xlat(h[10:8]))); // RQ6
                dst = xlat(h[7:5]); // RQ7
                bad = bad || instr_ext;
            end
            cssx_pkg::OP_THREE_REG: begin
                if (h[1:0] == cssx_pkg::FN_SUBTRACT) begin
                    op = cssx_pkg::CSSX_OP_SUBTRACT;
                end else begin
                    bad = 1'b1;
                end
                dst = xlat(h[4:2]); // RQ8
                bad = bad || instr_ext;
            end
            cssx_pkg::OP_WORD_STORE: begin
                op = cssx_pkg::CSSX_OP_STORE;
                if (instr_ext) begin
                    st_off = off_sx; // RQ11
                end else begin
                    st_off = {25'h0, h[4:0], 2'h0}; // RQ10
                end
            end
            cssx_pkg::OP_STACK_STORE: begin
                op = cssx_pkg::CSSX_OP_STORE;
                st_base = rd(cssx_pkg::STACK_REG); // RQ12
                sdata = rd(xlat(h[10:8])); // RQ12
                if (instr_ext) begin
                    st_off = off_sx; // RQ13
                    bad = bad || (h[7:5] != 3'h0);
                end else begin
                    st_off = {22'h0, h[7:0], 2'h0}; // RQ12
                end
            end
            default: begin
                bad = 1'b1;
            end
        endcase
        if (bad) begin
            op = cssx_pkg::CSSX_OP_NONE;
        end
    end

    // sign fill from bit 31, or zero fill
    assign sh_res = arith ? 32'($signed(sh_src) >>> shamt) // RQ2
                          : (sh_src >> shamt); // RQ3
    assign vaddr = st_base + st_off; // RQ10

    // fixed map: one unmapped window, identity elsewhere; no tlb here
    function automatic logic [34:0] translate(input logic [31:0] va);
        logic [34:0] r;
        r = {cssx_pkg::CCA_CACHED, va};
        if (va[31:30] == cssx_pkg::UNMAPPED_SEG) begin
            r[31:0] = {3'h0, va[28:0]};
            r[34:32] = va[29] ? cssx_pkg::CCA_UNCACHED
                              : cssx_pkg::CCA_CACHED;
        end
        return r;
    endfunction

    logic go, wb_en_d, st_valid_d, addr_err_d;
    logic [31:0] wb_val_d, rd_q;
    logic [34:0] xl;
    logic wb_en_q, st_valid_q, addr_err_q, illegal_q;
    logic [4:0] wb_idx_q;
    logic [31:0] wb_val_q, st_vaddr_q, st_paddr_q, st_data_q, bad_vaddr_q;
    logic [2:0] st_cca_q;

    assign go = ce && instr_valid;
    assign xl = translate(vaddr); // RQ15

    always_comb begin
        wb_en_d = 1'b0;
        wb_val_d = sh_res;
        st_valid_d = 1'b0;
        addr_err_d = 1'b0;
        unique case (op)
            cssx_pkg::CSSX_OP_SHIFT_IMM, cssx_pkg::CSSX_OP_SHIFT_VAR: begin
                wb_en_d = 1'b1;
            end
            cssx_pkg::CSSX_OP_SUBTRACT: begin
                wb_en_d = 1'b1;
                wb_val_d = sub_a - sub_b; // RQ8 RQ9
            end
            cssx_pkg::CSSX_OP_STORE: begin
                addr_err_d = (vaddr[1:0] != cssx_pkg::ALIGN_OK); // RQ14
                st_valid_d = !addr_err_d; // RQ14 RQ15
            end
            cssx_pkg::CSSX_OP_NONE: begin
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_GPR; i++) begin
                gpr_q[i] <= cssx_pkg::GPR_RESET;
            end
            wb_en_q <= 1'b0;
            wb_idx_q <= 5'h00;
            wb_val_q <= 32'h0000_0000;
            st_valid_q <= 1'b0;
            st_vaddr_q <= 32'h0000_0000;
            st_paddr_q <= 32'h0000_0000;
            st_cca_q <= 3'h0;
            st_data_q <= 32'h0000_0000;
            addr_err_q <= 1'b0;
            bad_vaddr_q <= 32'h0000_0000;
            illegal_q <= 1'b0;
            rd_q <= 32'h0000_0000;
        end else if (ce) begin
            // the executing instruction wins over the side write port
            if (go && wb_en_d) begin
                gpr_q[dst] <= wb_val_d; // RQ7 RQ16
            end else if (gpr_wr_en) begin
                gpr_q[gpr_wr_idx] <= gpr_wr_data;
            end
            wb_en_q <= go && wb_en_d;
            wb_idx_q <= dst;
            wb_val_q <= wb_val_d;
            st_valid_q <= go && st_valid_d;
            st_vaddr_q <= vaddr;
            st_paddr_q <= xl[31:0];
            st_cca_q <= xl[34:32];
            st_data_q <= sdata;
            addr_err_q <= go && addr_err_d;
            if (go && addr_err_d) begin
                bad_vaddr_q <= vaddr;
            end
            illegal_q <= go && bad;
            rd_q <= rd(gpr_rd_idx);
        end
    end

    assign gpr_rd_data = rd_q;
    assign wb_en = wb_en_q;
    assign wb_idx = wb_idx_q;
    assign wb_val = wb_val_q;
    assign st_valid = st_valid_q;
    assign st_vaddr = st_vaddr_q;
    assign st_paddr = st_paddr_q;
    assign st_cca = st_cca_q;
    assign st_data = st_data_q;
    assign addr_err = addr_err_q;
    assign bad_vaddr = bad_vaddr_q;
    assign illegal = illegal_q;

    shift_eight_a: assert property (@(posedge mclk) disable iff (rst) // RQ1
        go && op == cssx_pkg::CSSX_OP_SHIFT_IMM && !instr_ext && arith &&
        h[4:2] == 3'h0 |=> wb_val_q == 32'($signed($past(sh_src)) >>> 8))
        else $error("short shift of zero did not shift by eight");
    arith_fill_a: assert property (@(posedge mclk) disable iff (rst) // RQ2
        go && wb_en_d && op != cssx_pkg::CSSX_OP_SUBTRACT && arith
        |=> wb_val_q[31] == $past(sh_src[31]))
        else $error("arithmetic shift lost the sign fill");
    logic_fill_a: assert property (@(posedge mclk) disable iff (rst) // RQ3
        go && wb_en_d && op != cssx_pkg::CSSX_OP_SUBTRACT && !arith &&
        shamt != 5'h00 |=> !wb_val_q[31])
        else $error("logical shift did not fill with zero");
    ext_amount_a: assert property (@(posedge mclk) disable iff (rst) // RQ4
        go && op == cssx_pkg::CSSX_OP_SHIFT_IMM && instr_ext && !arith
        |=> wb_val_q == ($past(sh_src) >> $past(instr_word[26:22])))
        else $error("extended shift used the wrong amount");
    var_dest_a: assert property (@(posedge mclk) disable iff (rst) // RQ7
        go && op == cssx_pkg::CSSX_OP_SHIFT_VAR
        |=> wb_en_q && wb_idx_q == xlat($past(h[7:5])))
        else $error("variable shift wrote the wrong register");
    sub_wrap_a: assert property (@(posedge mclk) disable iff (rst) // RQ8
        go && op == cssx_pkg::CSSX_OP_SUBTRACT
        |=> wb_val_q == $past(sub_a) - $past(sub_b) && !addr_err_q) // RQ9
        else $error("subtract result or trap wrong");
    sp_base_a: assert property (@(posedge mclk) disable iff (rst) // RQ12
        go && op == cssx_pkg::CSSX_OP_STORE && !instr_ext &&
        major == cssx_pkg::OP_STACK_STORE
        |=> st_vaddr_q == $past(gpr_q[29]) + {22'h0, $past(h[7:0]), 2'h0})
        else $error("stack store address wrong");
    misalign_a: assert property (@(posedge mclk) disable iff (rst) // RQ14
        go && op == cssx_pkg::CSSX_OP_STORE && vaddr[1:0] != 2'h0
        |=> addr_err_q && !st_valid_q ##1
            !addr_err_q || $past(go) || !$past(ce))
        else $error("misaligned store not refused");
endmodule // cssx_exec
`default_nettype wire

// ### testbench/cssx_mem_model.sv
// data memory sink that records word writes from the store path
`timescale 1ns/100ps
`default_nettype none
module cssx_mem_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic st_valid,
    input wire logic [31:0] st_paddr,
    input wire logic [2:0] st_cca,
    input wire logic [31:0] st_data,
    output logic [7:0] wr_count,
    output logic [31:0] last_paddr,
    output logic [2:0] last_cca,
    output logic [31:0] last_data
);
    // accepts every write at once; a slow memory would stall the pipe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_count <= 8'h00;
            last_paddr <= 32'h0000_0000;
            last_cca <= 3'h0;
            last_data <= 32'h0000_0000;
        end else if (st_valid) begin
            wr_count <= wr_count + 8'h01;
            last_paddr <= st_paddr;
            last_cca <= st_cca;
            last_data <= st_data;
        end
    end
endmodule // cssx_mem_model
`default_nettype wire

// ### testbench/cssx_exec_bench.sv
// self-checking bench for the compact shift, subtract and store block
`timescale 1ns/100ps
`default_nettype none
module cssx_exec_bench;
    logic mclk = 1'b0, rst = 1'b1, iv = 1'b0, ie = 1'b0, we = 1'b0;
    logic [31:0] iw = 32'h0, wd = 32'h0, rdd, wbv, sva, spa, sd, bva;
    logic [4:0] wi = 5'h00, ri = 5'h00, wbi;
    logic ce = 1'b1;
    logic wbe, sv, ae, ill;
    logic [2:0] cca, mcca;
    logic [7:0] mcnt;
    logic [31:0] mpa, mdat;
    int n_errors = 0;
    int checks_done = 0;

    always #4 mclk = ~mclk;

    cssx_exec cssx_exec_inst (.mclk(mclk), .rst(rst), .ce(ce),
        .instr_valid(iv), .instr_ext(ie), .instr_word(iw),
        .gpr_wr_en(we), .gpr_wr_idx(wi), .gpr_wr_data(wd),
        .gpr_rd_idx(ri), .gpr_rd_data(rdd), .wb_en(wbe), .wb_idx(wbi),
        .wb_val(wbv), .st_valid(sv), .st_vaddr(sva), .st_paddr(spa),
        .st_cca(cca), .st_data(sd), .addr_err(ae), .bad_vaddr(bva),
        .illegal(ill));
    cssx_mem_model cssx_mem_model_inst (.mclk(mclk), .rst(rst),
        .st_valid(sv), .st_paddr(spa), .st_cca(cca), .st_data(sd),
        .wr_count(mcnt), .last_paddr(mpa), .last_cca(mcca),
        .last_data(mdat));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic ext, input logic [31:0] w);
        @(negedge mclk);
        ie = ext;
        iw = w;
        iv = 1'b1;
        @(negedge mclk);
        iv = 1'b0;
    endtask
    task automatic setr(input logic [4:0] i, input logic [31:0] v);
        @(negedge mclk);
        wi = i;
        wd = v;
        we = 1'b1;
        @(negedge mclk);
        we = 1'b0;
    endtask
    task automatic wbchk(input logic [4:0] i, input logic [31:0] v);
        chk({31'h0, wbe}, 32'h1);
        chk({27'h0, wbi}, {27'h0, i});
        chk(wbv, v);
    endtask
    task automatic stchk(input logic [31:0] va, pa, input logic [2:0] c);
        chk({31'h0, sv}, 32'h1);
        chk(sva, va);
        chk(spa, pa);
        chk({29'h0, cca}, {29'h0, c});
        chk(sd, 32'h8000_0010);
    endtask
    task automatic errchk(input logic [31:0] va);
        chk({30'h0, sv, ae}, 32'h1);
        chk(bva, va);
    endtask

    task automatic t_shift_imm;
        run(1'b0, {16'h0, 5'h06, 3'h1, 3'h3, 3'h0, 2'h3});
        wbchk(5'h11, 32'hFF80_0000);
        run(1'b0, {16'h0, 5'h06, 3'h1, 3'h3, 3'h3, 2'h2});
        wbchk(5'h11, 32'h1000_0002);
        run(1'b1, {5'h1E, 5'h1F, 6'h00, 5'h06, 3'h1, 3'h3, 5'h03});
        wbchk(5'h11, 32'hFFFF_FFFF);
        run(1'b1, {5'h1E, 5'h00, 6'h00, 5'h06, 3'h1, 3'h3, 5'h02});
        wbchk(5'h11, 32'h8000_0010);
        run(1'b1, {5'h1F, 5'h01, 6'h00, 5'h06, 3'h1, 3'h3, 5'h03});
        chk({30'h0, ill, wbe}, 32'h2);
        $display("test shift_imm done");
    endtask
    task automatic t_shift_var;
        run(1'b0, {16'h0, 5'h1D, 3'h4, 3'h5, 5'h07});
        wbchk(5'h05, 32'hFF00_0000);
        run(1'b0, {16'h0, 5'h1D, 3'h4, 3'h5, 5'h06});
        wbchk(5'h05, 32'h0FF0_0000);
        ri = 5'h05;
        @(negedge mclk);
        chk(rdd, 32'h0FF0_0000);
        $display("test shift_var done");
    endtask
    task automatic t_subtract;
        run(1'b0, {16'h0, 5'h1C, 3'h6, 3'h7, 3'h0, 2'h3});
        wbchk(5'h10, 32'hFFFF_FFFF);
        chk({31'h0, ill}, 32'h0);
        // low enable holds every output and blocks the taken edge
        ce = 1'b0;
        run(1'b0, {16'h0, 5'h1C, 3'h6, 3'h7, 3'h1, 2'h3});
        wbchk(5'h10, 32'hFFFF_FFFF);
        ce = 1'b1;
        ri = 5'h11;
        @(negedge mclk);
        chk(rdd, 32'h8000_0010);
        chk({31'h0, wbe}, 32'h0);
        $display("test subtract done");
    endtask
    task automatic t_store;
        run(1'b0, {16'h0, 5'h1B, 3'h2, 3'h3, 5'h1F});
        stchk(32'h1000_007C, 32'h1000_007C, 3'h3);
        run(1'b1, {5'h1E, 6'h3F, 5'h1F, 5'h1B, 3'h2, 3'h3, 5'h1C});
        stchk(32'h0FFF_FFFC, 32'h0FFF_FFFC, 3'h3);
        run(1'b0, {16'h0, 5'h1A, 3'h3, 8'hFF});
        stchk(32'hA000_03FC, 32'h0000_03FC, 3'h2);
        run(1'b1, {5'h1E, 6'h00, 5'h10, 5'h1A, 3'h3, 3'h0, 5'h00});
        stchk(32'h9FFF_8000, 32'h1FFF_8000, 3'h3);
        run(1'b1, {5'h1E, 6'h00, 5'h00, 5'h1A, 3'h3, 3'h0, 5'h02});
        errchk(32'hA000_0002);
        run(1'b1, {5'h1E, 6'h3F, 5'h1F, 5'h1B, 3'h2, 3'h3, 5'h1F});
        errchk(32'h0FFF_FFFF);
        @(negedge mclk);
        chk({24'h0, mcnt}, 32'h4);
        chk(mpa, 32'h1FFF_8000);
        chk({29'h0, mcca}, 32'h3);
        chk(mdat, 32'h8000_0010);
        $display("test store done");
    endtask

    task automatic close_out;
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        setr(5'h02, 32'h1000_0000);
        setr(5'h03, 32'h8000_0010);
        setr(5'h04, 32'h0000_0024);
        setr(5'h05, 32'hF000_0000);
        setr(5'h06, 32'h0000_0000);
        setr(5'h07, 32'h0000_0001);
        setr(5'h1D, 32'hA000_0000);
        t_shift_imm();
        t_shift_var();
        t_subtract();
        t_store();
        close_out();
    end

    // whole run is under a hundred cycles; twenty times that means a hang
    initial begin
        #16000;
        n_errors++;
        close_out();
    end
endmodule // cssx_exec_bench
`default_nettype wire
